// ==== cwmp_top.sv ====
// Purpose: Configuration words for memory partition and protection, AHB-Lite slave
// Assumes: MCLK 100 MHz, RESETN async active low, config words start erased at reset
// Notes: Zero-wait slave, every response OKAY
// Behaviour
// - LOW_VOLTAGE_PROG_ENABLE enable cannot be cleared during LOW_VOLTAGE_PROG_ENABLE
// - LOW_VOLTAGE_PROG_ENABLE set: pin is reset, enable ignored
// - Storage area writes blocked when bit 0
// - Data NVM writes blocked when bit 0
// - Config writes blocked when bit 0
// - Boot area writes blocked when bit 0
// - Application writes blocked when bit 0
// - Active protection stays until bulk erase
// - Boot enable is active low
// - Size code ignored while boot disabled
// - Size code locked once boot enabled
// - Size codes decode to fixed word counts
// - Boot area clamped to half memory
// - Code protection on when bit 0
// - Revision word bits 13:12 read 10
// - Revision word holds major and minor
// - Identity word reads 11 and part number
// - Protected self-write: no change, error set
// - Storage area top 128 words, no execute
// - Erased default: all flash is application
`timescale 1ns/1ns
`include "cwmp_regs.svh"
module cwmp_top #(
   parameter logic [5:0] MAJOR_REV = 6'h01, // Arbitrary value
   parameter logic [5:0] MINOR_REV = 6'h02, // Arbitrary value
   parameter logic [11:0] PART_ID = 12'h5a5 // Arbitrary value
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic LVP_SESSION, // Pin: programming runs over the LOW_VOLTAGE_PROG_ENABLE interface
   input wire logic RESET_PIN_EN_CFG, // Reset pin enable from another config word
   input wire logic [13:0] FETCH_ADDR, // Fetch address from the core
   output logic RESET_PIN_IS_RESET,
   output logic HV_PROG_REQUIRED,
   output logic CODE_PROTECT_ON,
   output logic SAF_ENABLED,
   output logic [14:0] BOOT_WORDS,
   output logic EXEC_VIOLATION,
   output logic NVM_WR_GO,
   output logic [13:0] NVM_WR_ADDR,
   output logic [1:0] NVM_WR_SPACE,
   output logic WRITE_ERROR
);
   //////////////////////////////////////////////////////////////////////////////
   // State
   logic [13:0] cfg4_reg; // Memory partition protect word
   logic [13:0] cfg5_reg; // Code protect word
   logic err_reg; // Sticky write error flag
   logic lvp_meta_reg; // First synchroniser stage
   logic lvp_sync_reg; // Synchronised LOW_VOLTAGE_PROG_ENABLE session level
   logic dp_valid_reg; // Data phase in progress
   logic dp_write_reg; // Data phase is a write
   logic dp_low_reg; // Address lies in the register window
   logic [15:0] dp_idx_reg; // Register index of the data phase
   logic [31:0] hrdata_reg;
   logic go_reg;
   logic [13:0] wa_reg;
   logic [1:0] ws_reg;
   logic rst_fn_reg;
   logic hv_reg;
   logic cp_reg;
   logic saf_reg;
   logic [14:0] bw_reg;
   logic viol_reg;
   logic ready_reg; // Bus ready, held high
   logic resp_reg; // Bus response, held at OKAY
   cwmp_map_if mif ();
   //////////////////////////////////////////////////////////////////////////////
   // Partition decoder
   cwmp_map u_map (
      .m(mif)
   );
   assign mif.boot_en_n = cfg4_reg[`CWMP_BOOT_AREA_ENABLE_N_BIT];
   assign mif.saf_en_n = cfg4_reg[`CWMP_STORAGE_AREA_ENABLE_N_BIT];
   assign mif.size_sel = cfg4_reg[2:0];
   assign mif.wr_addr = HWDATA[13:0];
   assign mif.fetch_addr = FETCH_ADDR;
   //////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire addr_ph = HSEL & HTRANS[1] & HREADY; // NONSEQ or SEQ taken
   wire wr_en = dp_valid_reg & dp_write_reg;
   wire hit_cfg4 = wr_en & dp_low_reg & (dp_idx_reg == `CWMP_IDX_CFG4);
   wire hit_cfg5 = wr_en & dp_low_reg & (dp_idx_reg == `CWMP_IDX_CFG5);
   wire hit_cmd = wr_en & dp_low_reg & (dp_idx_reg == `CWMP_IDX_CMD);
   wire hit_stat = wr_en & dp_low_reg & (dp_idx_reg == `CWMP_IDX_STAT);
   wire hit_ctrl = wr_en & dp_low_reg & (dp_idx_reg == `CWMP_IDX_CTRL);
   wire [15:0] ra_idx = HADDR[17:2];
   wire ra_low = (HADDR[31:18] == 14'h0000);
   //////////////////////////////////////////////////////////////////////////////
   // Read selection; unmapped indices read zero
   wire [13:0] rev_word = {`CWMP_REV_FIXED, MAJOR_REV, MINOR_REV};
   wire [13:0] dev_word = {`CWMP_DEVID_FIXED, PART_ID};
   wire [31:0] stat_word = {30'h00000000, lvp_sync_reg, err_reg};
   wire [31:0] cmd_word = {14'h0000, ws_reg, 2'h0, wa_reg};
   wire [31:0] rd_value = !ra_low ? 32'h00000000 :
      (ra_idx == `CWMP_IDX_CFG4) ? {18'h00000, cfg4_reg} :
      (ra_idx == `CWMP_IDX_CFG5) ? {18'h00000, cfg5_reg} :
      (ra_idx == `CWMP_IDX_REV) ? {18'h00000, rev_word} :
      (ra_idx == `CWMP_IDX_DEVID) ? {18'h00000, dev_word} :
      (ra_idx == `CWMP_IDX_STAT) ? stat_word :
      (ra_idx == `CWMP_IDX_CMD) ? cmd_word : 32'h00000000;
   //////////////////////////////////////////////////////////////////////////////
   // Config word writes; protection is the gate, sticky bits can only clear
   wire cfg_open = cfg4_reg[`CWMP_WCFG_BIT];
   wire erase = hit_ctrl & HWDATA[`CWMP_CTRL_ERASE_BIT];
   // LOW_VOLTAGE_PROG_ENABLE enable stays set while an LOW_VOLTAGE_PROG_ENABLE session runs
   wire lvp_next = HWDATA[`CWMP_LVP_BIT] | (lvp_sync_reg & cfg4_reg[`CWMP_LVP_BIT]);
   wire [4:0] wprot_next = cfg4_reg[11:7] & HWDATA[11:7];
   wire [1:0] en_next = cfg4_reg[4:3] & HWDATA[4:3];
   // Size code only moves while the boot area is still disabled
   wire [2:0] sz_next = cfg4_reg[`CWMP_BOOT_AREA_ENABLE_N_BIT] ? HWDATA[2:0] : cfg4_reg[2:0];
   wire [13:0] cfg4_next = {lvp_next, 1'b1, wprot_next, 2'h3, en_next, sz_next};
   wire [13:0] cfg5_next = {13'h1fff, cfg5_reg[`CWMP_CP_BIT] & HWDATA[`CWMP_CP_BIT]};
   //////////////////////////////////////////////////////////////////////////////
   // Self-write check against the target's protection bit
   wire [1:0] cmd_space = HWDATA[`CWMP_CMD_SPACE_LO +: 2];
   wire pfm_ok = (mif.wr_region == cwmp_pkg::CWMP_RG_BOOT) ? cfg4_reg[`CWMP_WBOOT_BIT] :
      (mif.wr_region == cwmp_pkg::CWMP_RG_SAF) ? cfg4_reg[`CWMP_WSAF_BIT] :
      cfg4_reg[`CWMP_WAPP_BIT];
   wire prot_ok = (cmd_space == cwmp_pkg::CWMP_SP_PFM) ? pfm_ok :
      (cmd_space == cwmp_pkg::CWMP_SP_DNVM) ? cfg4_reg[`CWMP_WDNVM_BIT] :
      (cmd_space == cwmp_pkg::CWMP_SP_CFG) ? cfg_open : 1'b0;
   wire cmd_refused = hit_cmd & !prot_ok;
   wire cfg_refused = (hit_cfg4 | hit_cfg5) & !cfg_open;
   // A new error wins over a clear in the same cycle
   wire err_next = cmd_refused | cfg_refused |
      (err_reg & !(hit_stat & HWDATA[`CWMP_STAT_ERR_BIT]));
   //////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser; only the second stage is read
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         lvp_meta_reg <= 1'b0;
         lvp_sync_reg <= 1'b0;
      end else begin
         lvp_meta_reg <= LVP_SESSION;
         lvp_sync_reg <= lvp_meta_reg;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Address phase capture and read data
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_low_reg <= 1'b0;
         dp_idx_reg <= 16'h0000;
         hrdata_reg <= 32'h00000000;
      end else begin
         dp_valid_reg <= addr_ph;
         dp_write_reg <= HWRITE;
         dp_low_reg <= ra_low;
         dp_idx_reg <= ra_idx;
         hrdata_reg <= (addr_ph & !HWRITE) ? rd_value : 32'h00000000;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Configuration words; bulk erase returns them to the erased state
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg4_reg <= `CWMP_CFG4_ERASED;
         cfg5_reg <= `CWMP_CFG5_ERASED;
      end else if (erase) begin
         cfg4_reg <= `CWMP_CFG4_ERASED;
         cfg5_reg <= `CWMP_CFG5_ERASED;
      end else begin
         if (hit_cfg4 & cfg_open) begin
            cfg4_reg <= cfg4_next;
         end
         if (hit_cfg5 & cfg_open) begin
            cfg5_reg <= cfg5_next;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Self-write launch and error flag
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         go_reg <= 1'b0;
         wa_reg <= 14'h0000;
         ws_reg <= 2'h0;
         err_reg <= 1'b0;
      end else begin
         // Refused writes never reach memory
         go_reg <= hit_cmd & prot_ok;
         if (hit_cmd) begin
            wa_reg <= HWDATA[13:0];
            ws_reg <= cmd_space;
         end
         err_reg <= err_next;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Decoded settings, registered so every output leaves a flip-flop
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_fn_reg <= 1'b1;
         hv_reg <= 1'b0;
         cp_reg <= 1'b0;
         saf_reg <= 1'b0;
         bw_reg <= 15'h0000;
         viol_reg <= 1'b0;
      end else begin
         // With LOW_VOLTAGE_PROG_ENABLE on the shared pin is reset and its enable bit is ignored
         rst_fn_reg <= cfg4_reg[`CWMP_LVP_BIT] | RESET_PIN_EN_CFG;
         hv_reg <= !cfg4_reg[`CWMP_LVP_BIT];
         cp_reg <= !cfg5_reg[`CWMP_CP_BIT];
         saf_reg <= !cfg4_reg[`CWMP_STORAGE_AREA_ENABLE_N_BIT];
         bw_reg <= mif.boot_words;
         viol_reg <= (mif.fetch_region == cwmp_pkg::CWMP_RG_SAF);
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Bus handshake flops; this slave never stalls and never errors, so both
   // sit at their reset level, yet they still leave a flip-flop like the rest
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ready_reg <= 1'b1;
         resp_reg <= 1'b0;
      end else begin
         ready_reg <= 1'b1;
         resp_reg <= 1'b0;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign HRDATA = hrdata_reg;
   assign HREADYOUT = ready_reg; // Always ready
   assign HRESP = resp_reg;
   assign RESET_PIN_IS_RESET = rst_fn_reg;
   assign HV_PROG_REQUIRED = hv_reg;
   assign CODE_PROTECT_ON = cp_reg;
   assign SAF_ENABLED = saf_reg;
   assign BOOT_WORDS = bw_reg;
   assign EXEC_VIOLATION = viol_reg;
   assign NVM_WR_GO = go_reg;
   assign NVM_WR_ADDR = wa_reg;
   assign NVM_WR_SPACE = ws_reg;
   assign WRITE_ERROR = err_reg;
   //////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);
   // A command write in its data phase
   sequence s_cmd_wr;
      hit_cmd;
   endsequence
   sequence s_refused;
      !NVM_WR_GO && WRITE_ERROR;
   endsequence
   // A command aimed at program memory
   sequence s_pfm_wr;
      s_cmd_wr ##0 (cmd_space == 2'h0);
   endsequence
   a_lvp_keep: assert property (
      lvp_sync_reg && cfg4_reg[13] && !erase |=> cfg4_reg[13])
      else $error("LOW_VOLTAGE_PROG_ENABLE enable cleared during LOW_VOLTAGE_PROG_ENABLE session");
   a_pin_reset: assert property (
      cfg4_reg[13] |=> RESET_PIN_IS_RESET && !HV_PROG_REQUIRED)
      else $error("Reset pin function wrong with LOW_VOLTAGE_PROG_ENABLE on");
   a_sticky_prot: assert property (
      !cfg4_reg[7] && !erase |=> !cfg4_reg[7] && $stable(cfg4_reg[7]))
      else $error("Application protection released without erase");
   a_size_lock: assert property (
      !cfg4_reg[3] && !erase |=> $stable(cfg4_reg[2:0]))
      else $error("Boot size changed while boot enabled");
   a_boot_off: assert property (
      cfg4_reg[3] |=> BOOT_WORDS == 15'h0000)
      else $error("Boot size not zero while disabled");
   a_boot_512: assert property (
      !cfg4_reg[3] && cfg4_reg[2:0] == 3'h7 |=> BOOT_WORDS == 15'h0200)
      else $error("Boot code 111 not 512 words");
   a_boot_clamp: assert property (
      BOOT_WORDS <= 15'h2000)
      else $error("Boot area above half memory");
   a_app_block: assert property (
      s_pfm_wr ##0 (mif.wr_region == cwmp_pkg::CWMP_RG_APP && !cfg4_reg[7]) |=> s_refused)
      else $error("Protected application write not refused");
   a_cp_out: assert property (
      !cfg5_reg[0] |=> CODE_PROTECT_ON)
      else $error("Code protection output not on");
   a_rev_bits: assert property (
      addr_ph && !HWRITE && ra_low && ra_idx == 16'h8005 |=> HRDATA[13:12] == 2'h2)
      else $error("Revision fixed bits wrong");
   // Revision fields pass through unchanged
   a_rev_fields: assert property (
      addr_ph && !HWRITE && ra_low && ra_idx == 16'h8005
      |=> HRDATA[11:0] == {MAJOR_REV, MINOR_REV})
      else $error("Revision fields wrong");
   a_dev_bits: assert property (
      addr_ph && !HWRITE && ra_low && ra_idx == 16'h8006 |=> HRDATA[13:12] == 2'h3)
      else $error("Identity fixed bits wrong");
   // Every size code of 0xx takes the largest size
   a_boot_code0: assert property (
      !cfg4_reg[3] && !cfg4_reg[2] |=> BOOT_WORDS == 15'h2000)
      else $error("Boot code 0xx not 8192 words");
   // Each protected target: no pulse, error raised one edge later
   a_boot_blk: assert property (
      s_pfm_wr ##0 (mif.wr_region == cwmp_pkg::CWMP_RG_BOOT && !cfg4_reg[8]) |=> s_refused)
      else $error("Protected boot write not refused");
   a_saf_blk: assert property (
      s_pfm_wr ##0 (mif.wr_region == cwmp_pkg::CWMP_RG_SAF && !cfg4_reg[11]) |=> s_refused)
      else $error("Protected storage write not refused");
   a_dnvm_blk: assert property (
      s_cmd_wr ##0 (cmd_space == 2'h1 && !cfg4_reg[10]) |=> s_refused)
      else $error("Protected data memory write not refused");
   // Config words themselves stay put when their protection is on
   a_cfg_block: assert property (
      (hit_cfg4 || hit_cfg5) && !cfg_open
      |=> $stable(cfg4_reg) && $stable(cfg5_reg) && WRITE_ERROR)
      else $error("Protected config write not refused");
   // An open target must see its write launched
   a_open_go: assert property (
      s_cmd_wr ##0 prot_ok |=> NVM_WR_GO)
      else $error("Permitted self-write not launched");
   // Storage area fetches are flagged, the boot area never reaches it
   a_exec_viol: assert property (
      !cfg4_reg[4] && FETCH_ADDR >= 14'h3f80 |=> EXEC_VIOLATION)
      else $error("Fetch from storage area not flagged");
   // Erased partition settings leave every address in the application
   a_app_default: assert property (
      cfg4_reg[3] && cfg4_reg[4] |-> mif.wr_region == cwmp_pkg::CWMP_RG_APP
      && mif.fetch_region == cwmp_pkg::CWMP_RG_APP)
      else $error("Default partition not all application");
endmodule : cwmp_top

// ==== cwmp_regs.svh ====
// Purpose: Register indices, field positions and fixed values of the config word block
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef CWMP_REGS_SVH
`define CWMP_REGS_SVH
// Register indices (byte address = index * 4)
`define CWMP_IDX_CFG4 16'h800a
`define CWMP_IDX_CFG5 16'h800b
`define CWMP_IDX_REV 16'h8005
`define CWMP_IDX_DEVID 16'h8006
`define CWMP_IDX_CMD 16'h8010
`define CWMP_IDX_STAT 16'h8011
`define CWMP_IDX_CTRL 16'h8012
// Memory partition word fields, then the code protect word bit
`define CWMP_LVP_BIT 13
`define CWMP_WSAF_BIT 11
`define CWMP_WDNVM_BIT 10
`define CWMP_WCFG_BIT 9
`define CWMP_WBOOT_BIT 8
`define CWMP_WAPP_BIT 7
`define CWMP_STORAGE_AREA_ENABLE_N_BIT 4
`define CWMP_BOOT_AREA_ENABLE_N_BIT 3
`define CWMP_CP_BIT 0
// Command, status and control fields
`define CWMP_CMD_SPACE_LO 16
`define CWMP_STAT_ERR_BIT 0
`define CWMP_STAT_LVP_BIT 1
`define CWMP_CTRL_ERASE_BIT 0
// Erased values of both configuration words
`define CWMP_CFG4_ERASED 14'h3fff
`define CWMP_CFG5_ERASED 14'h3fff
// Fixed identification bits 13:12
`define CWMP_REV_FIXED 2'h2
`define CWMP_DEVID_FIXED 2'h3
// Program memory geometry in words
`define CWMP_PFM_WORDS 15'h4000
`define CWMP_SAF_WORDS 15'h0080
`define CWMP_BOOT_MIN 15'h0200
`define CWMP_BOOT_MAX 15'h2000
`endif

// ==== cwmp_pkg.sv ====
// Purpose: Types shared by the config word block
// Assumes: Nothing beyond the header of constants
// Notes: Types only
package cwmp_pkg;
   // Target space of a self-write
   typedef enum logic [1:0] {CWMP_SP_PFM, CWMP_SP_DNVM, CWMP_SP_CFG, CWMP_SP_BAD} cwmp_space_t;
   // Program memory region of an address
   typedef enum logic [1:0] {CWMP_RG_BOOT, CWMP_RG_APP, CWMP_RG_SAF} cwmp_region_t;
endpackage : cwmp_pkg

// ==== cwmp_map_if.sv ====
// Purpose: Carries partition settings and addresses to the decoder and regions back
// Assumes: One clock domain, purely combinational signals
// Notes: ctl side is the main module, dec side the decoder
`timescale 1ns/1ns
interface cwmp_map_if;
   logic boot_en_n; // Boot area enable, active low
   logic saf_en_n; // Storage area enable, active low
   logic [2:0] size_sel; // Boot area size code
   logic [13:0] wr_addr; // Self-write word address
   logic [13:0] fetch_addr; // Instruction fetch address
   cwmp_pkg::cwmp_region_t wr_region; // Region of the write address
   cwmp_pkg::cwmp_region_t fetch_region; // Region of the fetch address
   logic [14:0] boot_words; // Decoded boot area size
   modport ctl (output boot_en_n, saf_en_n, size_sel, wr_addr, fetch_addr,
                input wr_region, fetch_region, boot_words);
   modport dec (input boot_en_n, saf_en_n, size_sel, wr_addr, fetch_addr,
                output wr_region, fetch_region, boot_words);
endinterface : cwmp_map_if

// ==== cwmp_map.sv ====
// Purpose: Decodes boot area size and classifies addresses into partitions
// Assumes: 16384-word program memory, addresses wrap inside it
// Notes: Pure combinational logic
`timescale 1ns/1ns
`include "cwmp_regs.svh"
module cwmp_map (
   cwmp_map_if.dec m
);
   //////////////////////////////////////////////////////////////////////////////
   // Boot area size, clamped to half of program memory
   function automatic logic [14:0] boot_size(input logic en_n, input logic [2:0] sel);
      logic [14:0] raw;
      logic [14:0] half;
      half = `CWMP_PFM_WORDS >> 1;
      // Codes 1xx double from the least size, codes 0xx all take the largest
      raw = sel[2] ? (`CWMP_BOOT_MIN << (3'h7 - sel)) : `CWMP_BOOT_MAX;
      if (raw > half) begin
         raw = half;
      end
      // Disabled boot area has no words and ignores the size code
      return en_n ? 15'h0000 : raw;
   endfunction : boot_size
   //////////////////////////////////////////////////////////////////////////////
   // Region of one address; boot never reaches the storage area since it is at most half
   function automatic cwmp_pkg::cwmp_region_t classify(input logic [13:0] a,
                                                      input logic [14:0] bw,
                                                      input logic saf_n);
      if ({1'b0, a} < bw) begin
         return cwmp_pkg::CWMP_RG_BOOT;
      end else if (!saf_n && ({1'b0, a} >= (`CWMP_PFM_WORDS - `CWMP_SAF_WORDS))) begin
         return cwmp_pkg::CWMP_RG_SAF;
      end
      return cwmp_pkg::CWMP_RG_APP;
   endfunction : classify
   //////////////////////////////////////////////////////////////////////////////
   // Both addresses share the same decoded limits
   assign m.boot_words = boot_size(m.boot_en_n, m.size_sel);
   assign m.wr_region = classify(m.wr_addr, m.boot_words, m.saf_en_n);
   assign m.fetch_region = classify(m.fetch_addr, m.boot_words, m.saf_en_n);
endmodule : cwmp_map

// ==== cwmp_nvm_model.sv ====
// Purpose: Self-write target model, records every accepted word write
// Assumes: One NVM_WR_GO pulse is one word written, same clock as the block
// Notes: No handshake on this link, so the model never stalls the block
`timescale 1ns/1ns
module cwmp_nvm_model (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic NVM_WR_GO,
   input wire logic [13:0] NVM_WR_ADDR,
   input wire logic [1:0] NVM_WR_SPACE,
   output logic [7:0] wr_count, // Accepted writes so far
   output logic [15:0] last_word // Space and address of the last write
);
   //////////////////////////////////////////////////////////////////////
   // Memory only changes on a pulse; a refused write must leave it alone
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_count <= 8'h00;
         last_word <= 16'h0000;
      end else if (NVM_WR_GO) begin
         wr_count <= wr_count + 8'h01;
         last_word <= {NVM_WR_SPACE, NVM_WR_ADDR};
      end
   end
endmodule : cwmp_nvm_model

// ==== tb_top.sv ====
// Purpose: Self-checking bench of the config word protection block
// Assumes: Zero-wait AHB-Lite slave, one clock, default identity parameters
// Notes: Expected values come from the field layout, never from the block
`timescale 1ns/1ns
`include "cwmp_regs.svh"
module tb_top;
   logic mclk, resetn, hsel, hwrite, low_voltage_prog_enable, pin_en;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, wr_space;
   logic [2:0] hsize;
   logic [13:0] fetch, wr_addr;
   logic [14:0] boot_words;
   logic hreadyout, hresp, pin_rst, hv_req, cp_on, saf_on, exec_viol, wr_go, wr_err;
   logic [7:0] wr_count;
   logic [15:0] last_word;
   wire hready; // Single slave, so its ready is the bus ready
   int num_errors = 0;
   int n_tests = 0;
   assign hready = hreadyout;
   cwmp_top dut (.MCLK(mclk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .LVP_SESSION(low_voltage_prog_enable),
      .RESET_PIN_EN_CFG(pin_en), .FETCH_ADDR(fetch), .RESET_PIN_IS_RESET(pin_rst),
      .HV_PROG_REQUIRED(hv_req), .CODE_PROTECT_ON(cp_on), .SAF_ENABLED(saf_on),
      .BOOT_WORDS(boot_words), .EXEC_VIOLATION(exec_viol), .NVM_WR_GO(wr_go),
      .NVM_WR_ADDR(wr_addr), .NVM_WR_SPACE(wr_space), .WRITE_ERROR(wr_err));
   cwmp_nvm_model nvm (.MCLK(mclk), .RESETN(resetn), .NVM_WR_GO(wr_go),
      .NVM_WR_ADDR(wr_addr), .NVM_WR_SPACE(wr_space), .wr_count(wr_count),
      .last_word(last_word));
   //////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : chk
   // One single transfer; waits on ready because the bus gives no fixed latency
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {14'h0, idx, 2'h0};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   // Registered outputs land one edge after the write takes effect
   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask : settle
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
      settle();
   endtask : wr
   task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 32'h0, q);
      chk(q, exp);
   endtask : rd
   // Self-write command; a refused one must raise the error and write nothing
   task automatic cmd(input logic [13:0] a, input logic [1:0] sp, input logic ok);
      logic [7:0] c0;
      c0 = wr_count;
      wr(`CWMP_IDX_CMD, {14'h0, sp, 2'h0, a});
      chk(32'(wr_count), 32'(c0 + {7'h0, ok}));
      chk(32'(wr_err), 32'(!ok));
      if (ok) chk(32'(last_word), {16'h0, sp, a});
      wr(`CWMP_IDX_STAT, 32'h1);
      chk(32'(wr_err), 32'h0);
   endtask : cmd
   //////////////////////////////////////////////////////////////////////
   // Erased state, identity words and decoded defaults
   task automatic t_reset();
      rd(`CWMP_IDX_CFG4, 32'h3fff);
      rd(`CWMP_IDX_CFG5, 32'h3fff);
      rd(`CWMP_IDX_REV, {18'h0, 2'h2, 6'h01, 6'h02});
      rd(`CWMP_IDX_DEVID, {18'h0, 2'h3, 12'h5a5});
      rd(16'h8100, 32'h0);
      chk(32'(pin_rst), 32'h1);
      chk(32'(boot_words), 32'h0);
      chk({saf_on, cp_on, hv_req}, 32'h0);
      fetch <= 14'h3f80;
      settle();
      chk(32'(exec_viol), 32'h0);
      cmd(14'h3f90, 2'h0, 1'b1);
      $display("t_reset done");
   endtask : t_reset
   // Programming enable held during a session, then cleared and set again; application protection sticky until erase
   task automatic t_lvp();
      @(posedge mclk);
      pin_en <= 1'b0;
      low_voltage_prog_enable <= 1'b1;
      repeat (3) @(posedge mclk);
      wr(`CWMP_IDX_CFG4, 32'h1fff);
      rd(`CWMP_IDX_CFG4, 32'h3fff);
      chk(32'(pin_rst), 32'h1);
      low_voltage_prog_enable <= 1'b0;
      repeat (3) @(posedge mclk);
      wr(`CWMP_IDX_CFG4, 32'h1fff);
      rd(`CWMP_IDX_CFG4, 32'h1fff);
      chk({pin_rst, hv_req}, 32'h1);
      pin_en <= 1'b1;
      settle();
      chk(32'(pin_rst), 32'h1);
      wr(`CWMP_IDX_CFG4, 32'h3f7f);
      wr(`CWMP_IDX_CFG4, 32'h3fff);
      rd(`CWMP_IDX_CFG4, 32'h3f7f);
      wr(`CWMP_IDX_CTRL, 32'h1);
      rd(`CWMP_IDX_CFG4, 32'h3fff);
      $display("t_lvp done");
   endtask : t_lvp
   // Every size code, ignored while disabled and locked once enabled
   task automatic t_boot();
      logic [14:0] e;
      for (int c = 7; c >= 0; c--) begin
         e = (c == 7) ? 15'h0200 : (c == 6) ? 15'h0400 : (c == 5) ? 15'h0800 :
             (c == 4) ? 15'h1000 : 15'h2000;
         wr(`CWMP_IDX_CTRL, 32'h1);
         wr(`CWMP_IDX_CFG4, {18'h0, 11'h7ff, 3'(c)});
         chk(32'(boot_words), 32'h0);
         wr(`CWMP_IDX_CFG4, {18'h0, 11'h7fe, 3'(c)});
         chk(32'(boot_words), 32'(e));
         wr(`CWMP_IDX_CFG4, {18'h0, 11'h7fe, ~3'(c)});
         rd(`CWMP_IDX_CFG4, {18'h0, 11'h7fe, 3'(c)});
      end
      $display("t_boot done");
   endtask : t_boot
   // Partitions, then each protection bit in turn, config protection last
   task automatic t_prot();
      int bits[5] = '{8, 7, 11, 10, 9};
      logic [13:0] ads[5] = '{14'h0010, 14'h1000, 14'h3f90, 14'h0, 14'h0};
      logic [1:0] sps[5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
      logic [31:0] v;
      wr(`CWMP_IDX_CTRL, 32'h1);
      wr(`CWMP_IDX_CFG4, 32'h3fef);
      wr(`CWMP_IDX_CFG4, 32'h3fe7);
      chk(32'(saf_on), 32'h1);
      chk(32'(exec_viol), 32'h1);
      @(posedge mclk);
      fetch <= 14'h3f7f;
      settle();
      chk(32'(exec_viol), 32'h0);
      for (int i = 0; i < 5; i++) cmd(ads[i], sps[i], 1'b1);
      cmd(14'h0, 2'h3, 1'b0);
      wr(`CWMP_IDX_CFG5, 32'h3ffe);
      chk(32'(cp_on), 32'h1);
      v = 32'h3fe7;
      for (int i = 0; i < 5; i++) begin
         v[bits[i]] = 1'b0;
         wr(`CWMP_IDX_CFG4, v);
         rd(`CWMP_IDX_CFG4, v);
         cmd(ads[i], sps[i], 1'b0);
         if (i == 0) cmd(14'h0200, 2'h0, 1'b1);
      end
      wr(`CWMP_IDX_CFG4, 32'h0);
      chk(32'(wr_err), 32'h1);
      rd(`CWMP_IDX_CFG4, v);
      wr(`CWMP_IDX_CTRL, 32'h1);
      rd(`CWMP_IDX_CFG4, 32'h3fff);
      $display("t_prot done");
   endtask : t_prot
   //////////////////////////////////////////////////////////////////////
   // Verdict, reached from the main sequence or the watchdog
   task automatic results();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // Free running 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Main sequence
   initial begin
      {resetn, hsel, hwrite, low_voltage_prog_enable, pin_en} = 5'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      fetch = 14'h0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_lvp();
      t_boot();
      t_prot();
      results();
   end
   // A hang counts as a mismatch; the tests need a few hundred cycles
   initial begin
      #200000;
      num_errors++;
      results();
   end
endmodule : tb_top
